// >>> verilog/flash_erase_pkg.sv
// Functional notes
// RULE1 - host sets the write latch with 06H before erasing; no latch, no erase
// RULE2 - 20H plus three address bytes erases the sector holding that address
// RULE3 - 52H plus three address bytes erases the 32KB block holding that address
// RULE4 - D8H plus three address bytes erases the 64KB block holding that address
// RULE5 - 60H or C7H alone erases the whole array, no address bytes
// RULE6 - address erases run only if select rises right after the 32nd bit
// RULE7 - array erase and power-down run only if select rises after 8th bit
// RULE8 - host keeps select low from first opcode bit to the last bit
// RULE9 - select rise ending a valid erase starts the timed erase cycle
// RULE10 - busy flag reads 1 during the erase cycle and 0 after it
// RULE11 - write latch is cleared before the erase cycle completes
// RULE12 - erase of a protected sector or block is not executed
// RULE13 - array erase needs low protect bits and invert bit all 0 or all 1
// RULE14 - only B9H enters power-down; there only ABH is obeyed
// RULE15 - select high with nothing running is ordinary standby, not power-down
// RULE16 - power-down is entered only after the entry delay following select rise
// RULE17 - B9H during a running cycle is rejected, cycle untouched
// RULE18 - after power-up the device is always in ordinary standby
// RULE19 - ABH alone wakes from power-down or leaves high-speed standby
// RULE20 - host keeps select high for the first wake time after waking
// RULE21 - ABH plus three dummy bytes shifts the id byte out msb first
// RULE22 - id byte repeats while clocks run, readout ends at select high
// RULE23 - wake with id readout resumes only after the second wake time
// RULE24 - ABH while busy is ignored and leaves the cycle untouched
package flash_erase_pkg;

    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned SECTOR_ERASE_NS = 50_000;
    localparam int unsigned BLOCK32_ERASE_NS = 100_000;
    localparam int unsigned BLOCK64_ERASE_NS = 150_000;
    localparam int unsigned ARRAY_ERASE_NS = 400_000;
    localparam int unsigned POWER_ENTRY_NS = 3_000;
    localparam int unsigned FIRST_WAKE_NS = 3_000;
    localparam int unsigned SECOND_WAKE_NS = 2_000;

    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
    localparam logic [7:0] OP_ARRAY_ERASE_A = 8'h60;
    localparam logic [7:0] OP_ARRAY_ERASE_B = 8'hC7;
    localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
    localparam logic [7:0] OP_LOWEST_POWER = 8'hB9;
    localparam logic [7:0] OP_WAKE_AND_ID = 8'hAB;

    localparam logic [5:0] OPCODE_BITS = 6'h08;
    localparam logic [5:0] FRAME_ADDR_BITS = 6'h20;
    localparam logic [5:0] BIT_CNT_MAX = 6'h3F;

    localparam int unsigned SECTOR_OFFSET_BITS = 12;
    localparam int unsigned BLOCK32_OFFSET_BITS = 15;
    localparam int unsigned BLOCK64_OFFSET_BITS = 16;

    // arbitrary value
    localparam logic [7:0] ID_BYTE_DEFAULT = 8'h5A;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_SECTOR,
        KIND_BLOCK32,
        KIND_BLOCK64,
        KIND_ARRAY
    } erase_kind_type;

    typedef struct packed {
        erase_kind_type kind;
        logic [23:0] addr;
    } erase_req_type;

endpackage

// >>> verilog/pin_sync.sv
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_type;

    sync_state_type st_reg;
    sync_state_type st_next;

    // first stage feeds only the second stage
    always_comb begin
        st_next.first = async_in;
        st_next.second = st_reg.first;
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_reg <= {RESET_VALUE, RESET_VALUE};
        end else begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.second;
endmodule

// >>> verilog/cycle_timer.sv
module cycle_timer #(
    parameter int WIDTH = 32
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] count_in,
    output logic done_out
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } timer_state_type;

    timer_state_type st_reg;
    timer_state_type st_next;

    always_comb begin
        st_next = st_reg;
        if (load_in) begin
            st_next.cnt = count_in;
        end else if (st_reg.cnt != '0) begin
            st_next.cnt = st_reg.cnt - WIDTH'(1);
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // done in the last counted cycle, so a load of n gives n busy cycles
    assign done_out = (st_reg.cnt == WIDTH'(1)) && !load_in;
endmodule

// >>> verilog/serial_flash_erase_powerdown.sv
module serial_flash_erase_powerdown #(
    parameter int unsigned SECTOR_ERASE_NS = flash_erase_pkg::SECTOR_ERASE_NS,
    parameter int unsigned BLOCK32_ERASE_NS = flash_erase_pkg::BLOCK32_ERASE_NS,
    parameter int unsigned BLOCK64_ERASE_NS = flash_erase_pkg::BLOCK64_ERASE_NS,
    parameter int unsigned ARRAY_ERASE_NS = flash_erase_pkg::ARRAY_ERASE_NS,
    parameter int unsigned POWER_ENTRY_NS = flash_erase_pkg::POWER_ENTRY_NS,
    parameter int unsigned FIRST_WAKE_NS = flash_erase_pkg::FIRST_WAKE_NS,
    parameter int unsigned SECOND_WAKE_NS = flash_erase_pkg::SECOND_WAKE_NS,
    parameter logic [7:0] ID_BYTE = flash_erase_pkg::ID_BYTE_DEFAULT
) (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic spi_clk_in,
    input wire logic chip_select_n_in,
    input wire logic serial_in,
    input wire logic [4:0] protect_range_bits_in,
    input wire logic protect_invert_bit_in,
    input wire logic region_protected_in,
    input wire logic high_speed_enter_in,
    output flash_erase_pkg::erase_req_type region_query_out,
    output flash_erase_pkg::erase_req_type erase_req_out,
    output logic erase_start_out,
    output logic erase_done_out,
    output logic erase_busy_flag_out,
    output logic write_latch_flag_out,
    output logic high_speed_standby_out,
    output logic lowest_power_out,
    output logic serial_out_out,
    output logic serial_out_oe_out
);
    function automatic int unsigned ns_to_cycles(input int unsigned ns);
        int unsigned c;
        c = (ns + flash_erase_pkg::CLK_PERIOD_NS - 1) / flash_erase_pkg::CLK_PERIOD_NS;
        return (c == 0) ? 1 : c;
    endfunction

    localparam int unsigned SECTOR_CYCLES = ns_to_cycles(SECTOR_ERASE_NS);
    localparam int unsigned BLOCK32_CYCLES = ns_to_cycles(BLOCK32_ERASE_NS);
    localparam int unsigned BLOCK64_CYCLES = ns_to_cycles(BLOCK64_ERASE_NS);
    localparam int unsigned ARRAY_CYCLES = ns_to_cycles(ARRAY_ERASE_NS);
    localparam int unsigned ENTRY_CYCLES = ns_to_cycles(POWER_ENTRY_NS);
    localparam int unsigned WAKE1_CYCLES = ns_to_cycles(FIRST_WAKE_NS);
    localparam int unsigned WAKE2_CYCLES = ns_to_cycles(SECOND_WAKE_NS);

    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_ERASE,
        ST_ENTRY_WAIT,
        ST_LOWEST_POWER,
        ST_WAKE_WAIT
    } mode_type;

    typedef struct packed {
        mode_type mode;
        logic sclk_prev;
        logic cs_n_prev;
        logic [5:0] bit_cnt;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [2:0] id_idx;
        logic so;
        logic so_oe;
        logic write_latch_flag;
        logic hss;
        logic busy;
        logic low_power;
        logic start;
        logic done;
        flash_erase_pkg::erase_req_type query;
        flash_erase_pkg::erase_req_type req;
    } core_state_type;

    function automatic flash_erase_pkg::erase_kind_type erase_kind(input logic [7:0] op);
        case (op)
            flash_erase_pkg::OP_SECTOR_ERASE: return flash_erase_pkg::KIND_SECTOR;
            flash_erase_pkg::OP_BLOCK32_ERASE: return flash_erase_pkg::KIND_BLOCK32;
            flash_erase_pkg::OP_BLOCK64_ERASE: return flash_erase_pkg::KIND_BLOCK64;
            flash_erase_pkg::OP_ARRAY_ERASE_A: return flash_erase_pkg::KIND_ARRAY;
            flash_erase_pkg::OP_ARRAY_ERASE_B: return flash_erase_pkg::KIND_ARRAY;
            default: return flash_erase_pkg::KIND_NONE;
        endcase
    endfunction

    // any address inside the region selects it, so the offset bits are dropped
    function automatic logic [23:0] region_base(input flash_erase_pkg::erase_kind_type k,
                                                input logic [23:0] a);
        case (k)
            flash_erase_pkg::KIND_SECTOR:
                return a & ~24'((1 << flash_erase_pkg::SECTOR_OFFSET_BITS) - 1);
            flash_erase_pkg::KIND_BLOCK32:
                return a & ~24'((1 << flash_erase_pkg::BLOCK32_OFFSET_BITS) - 1);
            flash_erase_pkg::KIND_BLOCK64:
                return a & ~24'((1 << flash_erase_pkg::BLOCK64_OFFSET_BITS) - 1);
            default: return 24'h000000;
        endcase
    endfunction

    function automatic logic [31:0] erase_cycles(input flash_erase_pkg::erase_kind_type k);
        case (k)
            flash_erase_pkg::KIND_SECTOR: return 32'(SECTOR_CYCLES);
            flash_erase_pkg::KIND_BLOCK32: return 32'(BLOCK32_CYCLES);
            flash_erase_pkg::KIND_BLOCK64: return 32'(BLOCK64_CYCLES);
            default: return 32'(ARRAY_CYCLES);
        endcase
    endfunction

    core_state_type st_reg;
    core_state_type st_next;
    logic [2:0] pins_sync;
    logic sclk_s;
    logic cs_n_s;
    logic si_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic id_phase;
    logic array_ok;
    logic timer_load;
    logic [31:0] timer_count;
    logic timer_done;

    // the link clock is only sampled here, its edges are found after two flops
    pin_sync #(
        .WIDTH(3),
        .RESET_VALUE(3'h2)
    ) u_pin_sync (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .async_in({spi_clk_in, chip_select_n_in, serial_in}),
        .sync_out(pins_sync)
    );

    assign sclk_s = pins_sync[2];
    assign cs_n_s = pins_sync[1];
    assign si_s = pins_sync[0];

    cycle_timer #(
        .WIDTH(32)
    ) u_timer (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .load_in(timer_load),
        .count_in(timer_count),
        .done_out(timer_done)
    );

    assign sclk_rise = sclk_s && !st_reg.sclk_prev && !cs_n_s;
    assign sclk_fall = !sclk_s && st_reg.sclk_prev && !cs_n_s;
    assign cs_rise = cs_n_s && !st_reg.cs_n_prev;
    assign id_phase = (st_reg.opcode == flash_erase_pkg::OP_WAKE_AND_ID) &&
                      (st_reg.bit_cnt >= flash_erase_pkg::FRAME_ADDR_BITS) &&
                      (st_reg.mode == ST_STANDBY || st_reg.mode == ST_LOWEST_POWER);
    assign array_ok = (protect_range_bits_in[2:0] == 3'h0 && !protect_invert_bit_in) ||
                      (protect_range_bits_in[2:0] == 3'h7 && protect_invert_bit_in); // [RULE13]

    always_comb begin
        st_next = st_reg;
        st_next.start = 1'b0;
        st_next.done = 1'b0;
        st_next.sclk_prev = sclk_s;
        st_next.cs_n_prev = cs_n_s;
        timer_load = 1'b0;
        timer_count = 32'h00000000;
        st_next.query.kind = erase_kind(st_reg.opcode);
        st_next.query.addr = region_base(erase_kind(st_reg.opcode), st_reg.addr);

        // a frame is only what lies between select fall and rise
        if (cs_n_s) begin
            st_next.bit_cnt = 6'h00;
            st_next.so_oe = 1'b0; // [RULE22]
            st_next.id_idx = 3'h0;
        end else if (sclk_rise) begin
            if (st_reg.bit_cnt < flash_erase_pkg::OPCODE_BITS) begin
                st_next.opcode = {st_reg.opcode[6:0], si_s};
            end else if (st_reg.bit_cnt < flash_erase_pkg::FRAME_ADDR_BITS) begin
                st_next.addr = {st_reg.addr[22:0], si_s};
            end
            if (st_reg.bit_cnt != flash_erase_pkg::BIT_CNT_MAX) begin
                st_next.bit_cnt = st_reg.bit_cnt + 6'h01;
            end
        end else if (sclk_fall && id_phase) begin
            st_next.so = ID_BYTE[~st_reg.id_idx]; // [RULE21]
            st_next.so_oe = 1'b1;
            st_next.id_idx = st_reg.id_idx + 3'h1; // [RULE22]
        end

        if (high_speed_enter_in && st_reg.mode == ST_STANDBY) begin
            st_next.hss = 1'b1;
        end

        if (timer_done) begin
            case (st_reg.mode)
                ST_ERASE: begin
                    st_next.mode = ST_STANDBY;
                    st_next.busy = 1'b0; // [RULE10]
                    st_next.done = 1'b1;
                end
                ST_ENTRY_WAIT: begin
                    st_next.mode = ST_LOWEST_POWER; // [RULE16]
                    st_next.low_power = 1'b1;
                end
                ST_WAKE_WAIT: begin
                    st_next.mode = ST_STANDBY; // [RULE20] [RULE23]
                end
                default: begin
                    st_next.mode = st_reg.mode;
                end
            endcase
        end else if (cs_rise) begin
            // commands arriving while busy fall through to the default branch
            case (st_reg.mode)
                ST_STANDBY: begin // [RULE15]
                    if (st_reg.bit_cnt == flash_erase_pkg::OPCODE_BITS) begin // [RULE7]
                        case (st_reg.opcode)
                            flash_erase_pkg::OP_WRITE_PERMIT: begin
                                st_next.write_latch_flag = 1'b1;
                                st_next.hss = 1'b0;
                            end
                            flash_erase_pkg::OP_WAKE_AND_ID: begin
                                st_next.hss = 1'b0; // [RULE19]
                            end
                            flash_erase_pkg::OP_LOWEST_POWER: begin
                                st_next.mode = ST_ENTRY_WAIT; // [RULE14] [RULE16]
                                st_next.hss = 1'b0;
                                timer_load = 1'b1;
                                timer_count = 32'(ENTRY_CYCLES);
                            end
                            flash_erase_pkg::OP_ARRAY_ERASE_A,
                            flash_erase_pkg::OP_ARRAY_ERASE_B: begin // [RULE5]
                                if (st_reg.write_latch_flag && array_ok) begin // [RULE1] [RULE13]
                                    st_next.mode = ST_ERASE; // [RULE9]
                                    st_next.busy = 1'b1;
                                    st_next.write_latch_flag = 1'b0; // [RULE11]
                                    st_next.start = 1'b1;
                                    st_next.req.kind = flash_erase_pkg::KIND_ARRAY;
                                    st_next.req.addr = 24'h000000;
                                    timer_load = 1'b1;
                                    timer_count = erase_cycles(flash_erase_pkg::KIND_ARRAY);
                                end
                            end
                            default: begin
                                st_next.mode = st_reg.mode;
                            end
                        endcase
                    end else if (st_reg.bit_cnt == flash_erase_pkg::FRAME_ADDR_BITS &&
                                 st_reg.query.kind != flash_erase_pkg::KIND_NONE &&
                                 st_reg.query.kind != flash_erase_pkg::KIND_ARRAY) begin // [RULE6]
                        // [RULE2] [RULE3] [RULE4]
                        if (st_reg.write_latch_flag && !region_protected_in) begin // [RULE1] [RULE12]
                            st_next.mode = ST_ERASE; // [RULE9]
                            st_next.busy = 1'b1;
                            st_next.write_latch_flag = 1'b0; // [RULE11]
                            st_next.start = 1'b1;
                            st_next.req = st_reg.query;
                            timer_load = 1'b1;
                            timer_count = erase_cycles(st_reg.query.kind);
                        end
                    end
                end
                ST_LOWEST_POWER: begin
                    // only the wake command is obeyed here
                    if (st_reg.opcode == flash_erase_pkg::OP_WAKE_AND_ID) begin // [RULE14]
                        if (st_reg.bit_cnt == flash_erase_pkg::OPCODE_BITS) begin
                            st_next.mode = ST_WAKE_WAIT; // [RULE19] [RULE20]
                            st_next.low_power = 1'b0;
                            timer_load = 1'b1;
                            timer_count = 32'(WAKE1_CYCLES);
                        end else if (st_reg.bit_cnt >= flash_erase_pkg::FRAME_ADDR_BITS) begin
                            st_next.mode = ST_WAKE_WAIT; // [RULE23]
                            st_next.low_power = 1'b0;
                            timer_load = 1'b1;
                            timer_count = 32'(WAKE2_CYCLES);
                        end
                    end
                end
                default: begin // [RULE17] [RULE24]
                    st_next.mode = st_reg.mode;
                end
            endcase
        end
    end

    // reset stands for power-up: always ordinary standby
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_reg <= '0; // [RULE18]
            st_reg.cs_n_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign region_query_out = st_reg.query;
    assign erase_req_out = st_reg.req;
    assign erase_start_out = st_reg.start;
    assign erase_done_out = st_reg.done;
    assign erase_busy_flag_out = st_reg.busy;
    assign write_latch_flag_out = st_reg.write_latch_flag;
    assign high_speed_standby_out = st_reg.hss;
    assign lowest_power_out = st_reg.low_power;
    assign serial_out_out = st_reg.so;
    assign serial_out_oe_out = st_reg.so_oe;

    logic [31:0] busy_len;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_len <= 32'h00000000;
        end else begin
            busy_len <= st_reg.busy ? busy_len + 32'h00000001 : 32'h00000000;
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    AST_START_WITH_BUSY: assert property ($rose(erase_busy_flag_out) |-> erase_start_out) // [RULE9]
        else $error("busy rose without an erase start");
    AST_START_NEEDS_LATCH: assert property (erase_start_out |-> $past(write_latch_flag_out)) // [RULE1]
        else $error("erase started without the write latch");
    AST_LATCH_CLEAR_AT_END: assert property ($fell(erase_busy_flag_out) |-> !write_latch_flag_out) // [RULE11]
        else $error("write latch still set at erase end");
    AST_NO_PROTECTED_ERASE: assert property (erase_start_out && // [RULE12]
        erase_req_out.kind != flash_erase_pkg::KIND_ARRAY |-> !$past(region_protected_in))
        else $error("protected region erased");
    AST_ARRAY_PROTECT: assert property (erase_start_out && // [RULE13]
        erase_req_out.kind == flash_erase_pkg::KIND_ARRAY |-> $past(array_ok))
        else $error("array erase with a protected sector");
    AST_BUSY_LENGTH: assert property ($fell(erase_busy_flag_out) |-> // [RULE10]
        $past(busy_len) + 32'h00000001 == erase_cycles(erase_req_out.kind))
        else $error("erase busy time wrong");
    AST_NO_POWERDOWN_BUSY: assert property (erase_busy_flag_out |-> !lowest_power_out) // [RULE17]
        else $error("power-down while erasing");
    AST_ENTRY_AFTER_DELAY: assert property ($rose(lowest_power_out) |->
        $past(st_reg.mode) == ST_ENTRY_WAIT && $past(timer_done)) // [RULE16]
        else $error("power-down entered without the entry delay");
    AST_NO_ID_WHILE_BUSY: assert property (erase_busy_flag_out |-> !serial_out_oe_out) // [RULE24]
        else $error("id driven during erase");
    AST_READOUT_ENDS: assert property (cs_rise |=> !serial_out_oe_out) // [RULE22]
        else $error("serial output still driven after select high");

    COV_SECTOR: cover property (erase_start_out &&
        erase_req_out.kind == flash_erase_pkg::KIND_SECTOR);
    COV_ARRAY: cover property (erase_start_out &&
        erase_req_out.kind == flash_erase_pkg::KIND_ARRAY);
    COV_POWER_CYCLE: cover property ($fell(lowest_power_out) ##[1:1000] st_reg.mode == ST_STANDBY);
    COV_ID_OUT: cover property ($rose(serial_out_oe_out));
endmodule

// >>> bench/spi_host_model.sv
module spi_host_model (
    output logic spi_clk_out,
    output logic chip_select_n_out,
    output logic serial_out,
    input wire logic serial_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        spi_clk_out = 1'b0;
        chip_select_n_out = 1'b1;
        serial_out = 1'b0;
    end
    // mode 0, clock rests low outside frames; released data line flips so it never looks held
    task automatic xfer(input int n, input logic [63:0] d, output logic [63:0] q);
        q = '0;
        chip_select_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_out = d[i];
            #24 spi_clk_out = 1'b1;
            q = {q[62:0], serial_in};
            #24 spi_clk_out = 1'b0;
        end
        #24 chip_select_n_out = 1'b1;
        serial_out = ~serial_out;
        #48;
    endtask
endmodule

// >>> bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [4:0] prot_bits = 5'h00;
    logic prot_inv = 1'b0;
    logic region_prot = 1'b0;
    logic hs_enter = 1'b0;
    logic sclk, cs_n, mosi, miso, miso_oe, start, done, busy, write_latch_flag, hs, lp;
    flash_erase_pkg::erase_req_type query, req;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int blen = 0;
    int nstart = 0;
    int ndone = 0;
    logic [63:0] rx;

    initial begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    // erase times cut to keep the run short; wake times stay at their defaults
    serial_flash_erase_powerdown #(.SECTOR_ERASE_NS(1000), .BLOCK32_ERASE_NS(1500),
        .BLOCK64_ERASE_NS(2000), .ARRAY_ERASE_NS(3000), .POWER_ENTRY_NS(100)) u_dut (
        .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .spi_clk_in(sclk),
        .chip_select_n_in(cs_n), .serial_in(mosi), .protect_range_bits_in(prot_bits),
        .protect_invert_bit_in(prot_inv), .region_protected_in(region_prot),
        .high_speed_enter_in(hs_enter), .region_query_out(query), .erase_req_out(req),
        .erase_start_out(start), .erase_done_out(done), .erase_busy_flag_out(busy),
        .write_latch_flag_out(write_latch_flag), .high_speed_standby_out(hs), .lowest_power_out(lp),
        .serial_out_out(miso), .serial_out_oe_out(miso_oe));

    // a released output shows the inverse, so a stale bit cannot pass for the id
    spi_host_model u_host (.spi_clk_out(sclk), .chip_select_n_out(cs_n), .serial_out(mosi),
        .serial_in(miso_oe ? miso : ~miso));

    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        // read outputs half a cycle away from the edge that launches them
        @(negedge ref_clk_in);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (start === 1'b1) begin
            blen <= 1;
            nstart <= nstart + 1;
        end else if (busy === 1'b1) begin
            blen <= blen + 1;
        end
        if (done === 1'b1) ndone <= ndone + 1;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end

    // meddle sends a wake then a power-down while the cycle runs; both must be ignored
    task automatic erase(input int n, input logic [63:0] d, input bit permit, input bit meddle,
        input int len, input logic [2:0] k, input logic [23:0] a);
        int s0;
        int d0;
        s0 = nstart;
        d0 = ndone;
        if (permit) u_host.xfer(8, 64'h06, rx);
        u_host.xfer(n, d, rx);
        if (meddle) begin
            u_host.xfer(32, 64'hAB000000, rx);
            u_host.xfer(8, 64'hB9, rx);
        end
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge ref_clk_in);
        tick(30);
        check(32'(nstart - s0), 32'(len != 0), "erase started");
        check(32'(ndone - d0), 32'(len != 0), "erase done");
        check(lp, 1'b0, "lowest power");
        if (len != 0) begin
            check(blen, len, "busy length");
            check(write_latch_flag, 1'b0, "write latch");
            check(req.kind, k, "erase kind");
            if (k != 3'h4) check(req.addr, a, "erase base");
            if (k != 3'h4) check(query.addr, a, "region query");
        end
    endtask

    initial begin
        tick(6);
        reset_n_in <= 1'b1;
        tick(3);
        check(busy, 1'b0, "busy after reset");
        check(lp, 1'b0, "power after reset");
        erase(32, 64'h20012345, 0, 0, 0, 3'h0, 24'h0);
        erase(32, 64'h20012345, 1, 0, 200, 3'h1, 24'h012000);
        erase(32, 64'h5201ABCD, 1, 0, 300, 3'h2, 24'h018000);
        erase(32, 64'hD801ABCD, 1, 0, 400, 3'h3, 24'h010000);
        erase(8, 64'h60, 1, 0, 600, 3'h4, 24'h0);
        erase(31, 64'h100091A2, 1, 0, 0, 3'h0, 24'h0);
        erase(9, 64'hC1, 1, 0, 0, 3'h0, 24'h0);
        tick(1);
        region_prot <= 1'b1;
        erase(32, 64'hD801ABCD, 1, 0, 0, 3'h0, 24'h0);
        tick(1);
        region_prot <= 1'b0;
        prot_bits <= 5'h01;
        erase(8, 64'hC7, 1, 0, 0, 3'h0, 24'h0);
        tick(1);
        prot_bits <= 5'h07;
        prot_inv <= 1'b1;
        erase(8, 64'hC7, 1, 0, 600, 3'h4, 24'h0);
        erase(8, 64'hC7, 1, 1, 600, 3'h4, 24'h0);
        u_host.xfer(8, 64'hB9, rx);
        tick(5);
        check(lp, 1'b0, "entry delay");
        tick(30);
        check(lp, 1'b1, "lowest power entered");
        u_host.xfer(8, 64'h06, rx);
        check(write_latch_flag, 1'b0, "latch in lowest power");
        u_host.xfer(8, 64'hAB, rx);
        tick(5);
        check(lp, 1'b0, "woken");
        // select stays high for the whole first wake time
        tick(620);
        u_host.xfer(48, 64'hAB0000000000, rx);
        check(rx[15:0], {2{flash_erase_pkg::ID_BYTE_DEFAULT}}, "id readout");
        check(miso_oe, 1'b0, "output released");
        tick(25);
        check(lp, 1'b0, "standby after frame");
        u_host.xfer(8, 64'hB9, rx);
        tick(30);
        check(lp, 1'b1, "lowest power again");
        // woken by the id frame: 06 refused inside the second wake time, taken after it
        u_host.xfer(32, 64'hAB000000, rx);
        u_host.xfer(8, 64'h06, rx);
        check(write_latch_flag, 1'b0, "latch inside second wake time");
        tick(300);
        u_host.xfer(8, 64'h06, rx);
        check(write_latch_flag, 1'b1, "latch after second wake time");
        tick(1);
        hs_enter <= 1'b1;
        tick(1);
        hs_enter <= 1'b0;
        tick(3);
        check(hs, 1'b1, "high speed entered");
        u_host.xfer(8, 64'hAB, rx);
        check(hs, 1'b0, "high speed left");
        conclude();
    end
endmodule
